/* File: dv/pasd_ctrl.sv */
`timescale 1ns/1ps

module pasd_ctrl (
    input  wire logic i_clk,
    output logic      o_shift_clk,
    output logic      o_data,
    output logic      o_strobe_n,
    output logic      o_sustain_n
);
    initial begin
        {o_shift_clk, o_data, o_strobe_n, o_sustain_n} = 4'hF;
    end
    // 25 low + 25 high cycles: 250 ns per bit, msb of the n bits first
    task automatic send(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_clk) o_shift_clk <= 1'b0;
            o_data <= w[i];
            repeat (25) @(posedge i_clk);
            o_shift_clk <= 1'b1;
            repeat (24) @(posedge i_clk);
        end
    endtask
    // strobe only when the caller asks, settle 6 edges
    task automatic pins(input logic strobe_n, input logic sustain_n);
        @(posedge i_clk) o_strobe_n <= strobe_n;
        o_sustain_n <= sustain_n;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps

module tb;
    import pasd_pkg::*;
    logic        i_clk;
    logic        i_rst;
    logic        shift_clk;
    logic        data;
    logic        strobe_n;
    logic        sustain_n;
    logic [31:0] o_out;
    int          fails;
    int          checks_done;
    typedef struct packed {
        logic [31:0] word;
        logic [31:0] strobed;
    } pasd_row_s;
    // a stored zero pulls its output low under strobe, a one leaves it high
    pasd_row_s   rows [5] = '{
        '{32'h00000000, 32'h00000000},
        '{32'hFFFFFFFF, 32'hFFFFFFFF},
        '{32'h80000001, 32'h80000001},
        '{32'hA5C30F81, 32'hA5C30F81},
        '{32'h7FFFFFFE, 32'h7FFFFFFE}
    };

    pasd_ctrl u_ctl (
        .i_clk       (i_clk),
        .o_shift_clk (shift_clk),
        .o_data      (data),
        .o_strobe_n  (strobe_n),
        .o_sustain_n (sustain_n)
    );

    pasd_core dut (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_shift_clk (shift_clk),
        .i_data      (data),
        .i_strobe_n  (strobe_n),
        .i_sustain_n (sustain_n),
        .o_out       (o_out)
    );

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check_out(input string name, input logic [31:0] exp);
        @(negedge i_clk);
        checks_done++;
        if (o_out !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, o_out);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // about 42 us of traffic expected
    initial begin
        #200000;
        fails++;
        finish_test();
    end

    initial begin
        fails = 0;
        checks_done = 0;
        i_rst = 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        check_out("reset out", OUT_IDLE);
        foreach (rows[i]) begin
            u_ctl.send(rows[i].word, STAGES);
            repeat (6) @(posedge i_clk);
            check_out("idle out", OUT_IDLE);
            u_ctl.pins(1'b0, 1'b1);
            check_out("strobed out", rows[i].strobed);
            u_ctl.pins(1'b1, 1'b1);
            check_out("released out", OUT_IDLE);
        end
        // sustain must win over an active strobe
        u_ctl.pins(1'b0, 1'b0);
        check_out("sustain out", OUT_LOW);
        u_ctl.pins(1'b1, 1'b0);
        check_out("sustain only", OUT_LOW);
        u_ctl.pins(1'b0, 1'b1);
        check_out("kept data", rows[4].strobed);
        u_ctl.pins(1'b1, 1'b1);
        // a reset in mid-run must refill the register with ones
        @(posedge i_clk) i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        check_out("reset again", OUT_IDLE);
        u_ctl.pins(1'b0, 1'b1);
        check_out("strobe after reset", SHIFT_RESET);
        // four zeros shifted under strobe enter at stage 0 and fill stages 0 to 3
        u_ctl.send(32'h00000000, 4);
        repeat (6) @(posedge i_clk);
        check_out("partial word", 32'hFFFFFFF0);
        u_ctl.pins(1'b1, 1'b1);
        finish_test();
    end
endmodule

/* File: rtl/pasd_core.sv */
`timescale 1ns/1ps

module pasd_core (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_shift_clk,
    input  wire logic        i_data,
    input  wire logic        i_strobe_n,
    input  wire logic        i_sustain_n,
    output logic      [31:0] o_out
);
    import pasd_pkg::*;

    logic [SYNC_WIDTH-1:0]     pins_s;
    logic                      clk_prev;
    logic                      shift_rise;
    logic                      data_s;
    logic                      strobe_s;
    logic                      sustain_s;
    logic [STAGES-1:0]         sr;
    logic [STAGES-1:0]         next_out;
    logic                      first_q;
    logic [$clog2(STAGES)-1:0] shift_count;

    // pins cross into i_clk through two flops each
    pasd_sync u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_sustain_n, i_strobe_n, i_data, i_shift_clk}),
        .o_sync  (pins_s)
    );

    assign data_s     = pins_s[SYNC_DATA];
    assign strobe_s   = pins_s[SYNC_STROBE];
    assign sustain_s  = pins_s[SYNC_SUSTAIN];
    assign shift_rise = pins_s[SYNC_CLK] & ~clk_prev;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_prev <= 1'b1;
        end else begin
            clk_prev <= pins_s[SYNC_CLK];
        end
    end

    // all ones after reset, so a strobe before any shift pulls nothing low
    // the register sees only the logic inputs, never the output supply
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sr <= SHIFT_RESET;
        end else if (shift_rise) begin
            sr <= {sr[LAST_STAGE-1:0], data_s};
        end
    end

    // per output view of the strobe, so one stuck bit names itself
    property p_bit_low(stored, level);
        @(posedge i_clk) disable iff (i_rst)
        sustain_s && !strobe_s && !stored |=> !level;
    endproperty

    property p_bit_high(stored, level);
        @(posedge i_clk) disable iff (i_rst)
        sustain_s && !strobe_s && stored |=> level;
    endproperty

    // every output decides independently, no section grouping
    genvar k;
    generate
        for (k = 0; k < STAGES; k++) begin : g_out
            always_comb begin
                if (!sustain_s) begin
                    next_out[k] = 1'b0;
                end else if (!strobe_s) begin
                    next_out[k] = sr[k];
                end else begin
                    next_out[k] = 1'b1;
                end
            end

            a_bit_low: assert property (p_bit_low(sr[k], o_out[k])) else $error("bit zero, output high");
            a_bit_high: assert property (p_bit_high(sr[k], o_out[k])) else $error("bit one, output low");
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_out <= OUT_IDLE;
        end else begin
            o_out <= next_out;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // counts shift edges modulo one word, so a cover can see a full load
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_count <= '0;
        end else if (shift_rise) begin
            shift_count <= shift_count + 1'b1;
        end
    end

    property p_shift_capture;
        @(posedge i_clk) disable iff (i_rst)
        shift_rise |=> sr[0] == $past(data_s);
    endproperty
    a_shift_capture: assert property (p_shift_capture) else $error("shift did not capture data");

    property p_shift_move;
        @(posedge i_clk) disable iff (i_rst)
        shift_rise |=> sr[LAST_STAGE:1] == $past(sr[LAST_STAGE-1:0]);
    endproperty
    a_shift_move: assert property (p_shift_move) else $error("bits did not advance one stage");

    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
        !shift_rise |=> sr == $past(sr);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without shift edge");

    property p_sustain;
        @(posedge i_clk) disable iff (i_rst)
        !sustain_s |=> o_out == OUT_LOW;
    endproperty
    a_sustain: assert property (p_sustain) else $error("sustain did not force outputs low");

    // the chain restarts at ones, so a pin held low through release shows late
    property p_sustain_pin;
        @(posedge i_clk) disable iff (i_rst)
        (!first_q && !i_sustain_n) [*3] |=> o_out == OUT_LOW;
    endproperty
    a_sustain_pin: assert property (p_sustain_pin) else $error("sustain pin latency too long");

    property p_strobe;
        @(posedge i_clk) disable iff (i_rst)
        sustain_s && !strobe_s |=> o_out == $past(sr);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobed outputs differ from stored bits");

    property p_idle;
        @(posedge i_clk) disable iff (i_rst)
        sustain_s && strobe_s |=> o_out == OUT_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("idle outputs not high");

    property p_open_inputs;
        @(posedge i_clk) disable iff (i_rst)
        first_q |-> strobe_s && sustain_s && data_s && o_out == OUT_IDLE;
    endproperty
    a_open_inputs: assert property (p_open_inputs) else $error("inputs not read as one after reset");

    // a pin rise becomes one shift edge, two edges after the high level is sampled
    property p_shift_pin;
        @(posedge i_clk) disable iff (i_rst)
        (!first_q && !i_shift_clk) ##1 i_shift_clk |-> ##2 shift_rise;
    endproperty
    a_shift_pin: assert property (p_shift_pin) else $error("pin rise did not give a shift");

    // a glitch inside the edge detector would shift without any pin rise
    property p_shift_cause;
        @(posedge i_clk) disable iff (i_rst)
        shift_rise |-> $past(i_shift_clk, 2) && !$past(i_shift_clk, 3);
    endproperty
    a_shift_cause: assert property (p_shift_cause) else $error("shift without a pin rise");

    property p_idle_pin;
        @(posedge i_clk) disable iff (i_rst)
        (!first_q && i_sustain_n && i_strobe_n) [*3] |=> o_out == OUT_IDLE;
    endproperty
    a_idle_pin: assert property (p_idle_pin) else $error("idle pins did not give high outputs");

    // no output may go low unless strobe or sustain asked for it
    property p_low_cause;
        @(posedge i_clk) disable iff (i_rst)
        o_out != OUT_IDLE |-> $past(!sustain_s || !strobe_s);
    endproperty
    a_low_cause: assert property (p_low_cause) else $error("output low without a cause");

    c_shift: cover property (
        @(posedge i_clk) disable iff (i_rst)
        shift_rise && !data_s
    );

    c_strobe: cover property (
        @(posedge i_clk) disable iff (i_rst)
        sustain_s && !strobe_s && sr != SHIFT_RESET
    );

    c_sustain: cover property (
        @(posedge i_clk) disable iff (i_rst)
        !sustain_s ##1 sustain_s
    );

    c_full_word: cover property (
        @(posedge i_clk) disable iff (i_rst)
        shift_rise && shift_count == LAST_STAGE
    );

    c_all_low: cover property (
        @(posedge i_clk) disable iff (i_rst)
        (sustain_s && !strobe_s && sr == OUT_LOW) ##1 o_out == OUT_LOW
    );
endmodule

/* File: rtl/pasd_sync.sv */
`timescale 1ns/1ps

package pasd_pkg;
    localparam int          STAGES       = 32;
    localparam int          LAST_STAGE   = STAGES - 1;
    localparam int          SYNC_WIDTH   = 4;
    localparam int          SYNC_CLK     = 0;
    localparam int          SYNC_DATA    = 1;
    localparam int          SYNC_STROBE  = 2;
    localparam int          SYNC_SUSTAIN = 3;
    localparam logic [3:0]  SYNC_RESET   = 4'hF;
    localparam logic [31:0] OUT_IDLE     = 32'hFFFFFFFF;
    localparam logic [31:0] OUT_LOW      = 32'h00000000;
    localparam logic [31:0] SHIFT_RESET  = 32'hFFFFFFFF;
    localparam int          CLK_PERIOD_PS     = 5000;
    localparam int          SHIFT_MIN_PERIOD_NS = 250;
    localparam int          SHIFT_MIN_CYCLES  =
        (SHIFT_MIN_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

module pasd_sync (
    input  wire logic                           i_clk,
    input  wire logic                           i_rst,
    input  wire logic [pasd_pkg::SYNC_WIDTH-1:0] i_async,
    output logic      [pasd_pkg::SYNC_WIDTH-1:0] o_sync
);
    import pasd_pkg::*;

    logic [SYNC_WIDTH-1:0] meta;

    // open pins idle high, so the chain starts at one
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= SYNC_RESET;
            o_sync <= SYNC_RESET;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule
